// ===== resolver_pkg.sv
// register map, field layout and sizes for the private address resolver
// assumes a 32-bit apb register bus and a byte-wide memory read port
// Functional notes
// RULE_01 - the controller may start once the first six address bytes sit in ram
// RULE_02 - the controller loads the address pointer before starting resolution
// RULE_03 - the key table is read from ram at the key table pointer
// RULE_04 - keys are sixteen bytes, back to back; key n at offset 16*n
// RULE_05 - writing 1 to bit 0 of start task begins resolution
// RULE_06 - writing the stop task halts a resolution in progress
// RULE_07 - the done event flag is set when resolution finishes
// RULE_08 - match flag set when a key resolves; no-match flag when none does
// RULE_09 - writing 1 to enable set bits enables that event's interrupt; reads enables
// RULE_10 - writing 1 to enable clear bits disables that event's interrupt; reads enables
// RULE_11 - writable key table, address and scratch pointer registers
// RULE_12 - block enable field: 0 disables the resolver, 3 enables it
// RULE_13 - key count accepts 1 to 16 keys tried, resets to 1
// RULE_14 - status reports the four-bit index of the last matching key
// RULE_15 - keys tried from key 0, stop at first match or count, then done
// RULE_16 - task writes with bit 0 clear do nothing; flags stay until written 0
package resolver_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register offsets
    localparam logic [11:0] OFS_START = 12'h000;
    localparam logic [11:0] OFS_STOP = 12'h008;
    localparam logic [11:0] OFS_DONE = 12'h100;
    localparam logic [11:0] OFS_MATCH = 12'h104;
    localparam logic [11:0] OFS_NOMATCH = 12'h108;
    localparam logic [11:0] OFS_IRQ_SET = 12'h304;
    localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
    localparam logic [11:0] OFS_STATUS = 12'h400;
    localparam logic [11:0] OFS_ENABLE = 12'h500;
    localparam logic [11:0] OFS_KEY_COUNT = 12'h504;
    localparam logic [11:0] OFS_KEY_PTR = 12'h508;
    localparam logic [11:0] OFS_ADDR_PTR = 12'h510;
    localparam logic [11:0] OFS_SCRATCH_PTR = 12'h514;

    // event bit positions, shared by flags, enables and interrupt logic
    localparam int EV_DONE = 0;
    localparam int EV_MATCH = 1;
    localparam int EV_NOMATCH = 2;
    localparam int NUM_EVENTS = 3;

    // field values and reset values
    localparam logic [1:0] ENABLE_ON = 2'h3;
    localparam logic [1:0] ENABLE_RESET = 2'h0;
    localparam logic [4:0] KEY_COUNT_MIN = 5'h01;
    localparam logic [4:0] KEY_COUNT_MAX = 5'h10;
    localparam logic [4:0] KEY_COUNT_RESET = 5'h01;
    localparam logic [31:0] PTR_RESET = 32'h00000000;

    // memory layout of the address and key table
    localparam int ADDR_BYTES = 6;
    localparam int HASH_BYTES = 3;
    localparam int KEY_BYTES = 16;
    localparam logic [4:0] ADDR_LAST = 5'h05;
    localparam logic [4:0] KEY_LAST = 5'h0F;
endpackage

// ===== key_check_if.sv
// handshake between the resolver sequencer and its key checker
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface key_check_if;
    logic start;
    logic [127:0] key;
    logic [23:0] prand;
    logic [23:0] hash;
    logic done;
    logic match;
    modport requester (output start, output key, output prand, output hash,
                       input done, input match);
    modport responder (input start, input key, input prand, input hash,
                       output done, output match);
endinterface

// ===== key_checker.sv
// key checker: tries one key against the captured address
// assumes key, prand and hash stay stable from start until done
// the mixing below is a replaceable stand-in for the real hash
`timescale 1ns/100ps
module key_checker (
    input wire logic pclk,
    input wire logic presetn,
    key_check_if.responder chk
);
    import resolver_pkg::*;

    typedef struct packed {
        logic busy;
        logic [4:0] cnt;
        logic [23:0] acc;
        logic done;
        logic match;
    } check_state_t;

    check_state_t s;
    check_state_t next_s;
    logic [7:0] kbyte;

    // one key byte folded per cycle, sixteen cycles per key
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        kbyte = chk.key[s.cnt[3:0]*8 +: 8];
        if (chk.start) begin
            next_s.busy = 1'b1;
            next_s.cnt = 5'h00;
            next_s.acc = chk.prand;
            next_s.match = 1'b0;
        end else if (s.busy) begin
            next_s.acc = {s.acc[22:0], s.acc[23]} ^ {kbyte, kbyte ^ chk.prand[7:0], kbyte};
            next_s.cnt = s.cnt + 5'h01;
            if (s.cnt == KEY_LAST) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
                next_s.match = (next_s.acc == chk.hash);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign chk.done = s.done;
    assign chk.match = s.match;
endmodule

// ===== address_resolver.sv
// private address resolver: apb registers, byte-wide ram fetch and key loop
// assumes ram answers mem_req with a one-cycle mem_ack on pclk
`timescale 1ns/100ps
module address_resolver (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [resolver_pkg::ADDR_W-1:0] paddr,
    input wire logic [resolver_pkg::DATA_W-1:0] pwdata,
    output logic [resolver_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic [31:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    output logic irq
);
    import resolver_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH_ADDR = 3'b001,
        ST_FETCH_KEY = 3'b010,
        ST_CHECK = 3'b011
    } state_t;

    typedef struct packed {
        state_t fsm;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [2:0] events;
        logic [2:0] inten;
        logic [3:0] last_match;
        logic [1:0] enable;
        logic [4:0] key_count;
        logic [31:0] key_ptr;
        logic [31:0] addr_ptr;
        logic [31:0] scratch_ptr;
        logic [3:0] key_idx;
        logic [4:0] byte_idx;
        logic [47:0] addr;
        logic [127:0] key;
        logic mem_req;
        logic [31:0] mem_addr;
        logic chk_start;
        logic irq;
    } resolver_state_t;

    resolver_state_t s;
    resolver_state_t next_s;

    key_check_if chk ();

    logic [31:0] rd_value;
    logic rd_hit;
    logic wr_fire;
    logic start_req;
    logic stop_req;
    logic [2:0] ev_clr;
    logic [2:0] hw_set;
    logic enabled;
    logic [31:0] key_base;
    logic [31:0] fetch_base;

    // hash sits in the low three bytes, the random part above it
    assign chk.start = s.chk_start;
    assign chk.key = s.key;
    assign chk.hash = s.addr[HASH_BYTES*8-1:0];
    assign chk.prand = s.addr[ADDR_BYTES*8-1:HASH_BYTES*8];

    key_checker checker_inst (
        .pclk(pclk),
        .presetn(presetn),
        .chk(chk)
    );

    // register read mux, decoded during the first access cycle
    always_comb begin
        rd_value = 32'h00000000;
        rd_hit = 1'b1;
        case (paddr)
            OFS_START: begin
                rd_value = 32'h00000000;
            end
            OFS_STOP: begin
                rd_value = 32'h00000000;
            end
            OFS_DONE: begin
                rd_value = {31'h00000000, s.events[EV_DONE]};
            end
            OFS_MATCH: begin
                rd_value = {31'h00000000, s.events[EV_MATCH]};
            end
            OFS_NOMATCH: begin
                rd_value = {31'h00000000, s.events[EV_NOMATCH]};
            end
            OFS_IRQ_SET: begin
                rd_value = {29'h00000000, s.inten}; // RULE_09
            end
            OFS_IRQ_CLR: begin
                rd_value = {29'h00000000, s.inten}; // RULE_10
            end
            OFS_STATUS: begin
                rd_value = {28'h0000000, s.last_match}; // RULE_14
            end
            OFS_ENABLE: begin
                rd_value = {30'h00000000, s.enable};
            end
            OFS_KEY_COUNT: begin
                rd_value = {27'h0000000, s.key_count};
            end
            OFS_KEY_PTR: begin
                rd_value = s.key_ptr;
            end
            OFS_ADDR_PTR: begin
                rd_value = s.addr_ptr;
            end
            OFS_SCRATCH_PTR: begin
                rd_value = s.scratch_ptr;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // key n starts sixteen bytes after key n-1
    assign key_base = s.key_ptr + 32'(s.key_idx) * 32'(KEY_BYTES); // RULE_03 RULE_04
    assign fetch_base = (s.fsm == ST_FETCH_ADDR) ? s.addr_ptr : key_base;
    assign enabled = (s.enable == ENABLE_ON); // RULE_12

    // next-state logic: bus, register writes, sequencer, events
    always_comb begin
        next_s = s;
        next_s.chk_start = 1'b0;
        start_req = 1'b0;
        stop_req = 1'b0;
        ev_clr = 3'h0;
        hw_set = 3'h0;
        wr_fire = psel && penable && s.pready && pwrite;

        // apb: one wait state, then pready for a single cycle
        if (psel && penable && !s.pready) begin
            next_s.pready = 1'b1;
            next_s.prdata = rd_value;
            next_s.pslverr = !rd_hit;
        end else begin
            next_s.pready = 1'b0;
            next_s.pslverr = 1'b0;
        end

        // writes take effect at the edge that completes the transfer
        if (wr_fire) begin
            case (paddr)
                OFS_START: begin
                    start_req = pwdata[0]; // RULE_05 RULE_16
                end
                OFS_STOP: begin
                    stop_req = pwdata[0]; // RULE_06 RULE_16
                end
                OFS_DONE: begin
                    ev_clr[EV_DONE] = !pwdata[0]; // RULE_16
                end
                OFS_MATCH: begin
                    ev_clr[EV_MATCH] = !pwdata[0]; // RULE_16
                end
                OFS_NOMATCH: begin
                    ev_clr[EV_NOMATCH] = !pwdata[0]; // RULE_16
                end
                OFS_IRQ_SET: begin
                    next_s.inten = s.inten | pwdata[NUM_EVENTS-1:0]; // RULE_09
                end
                OFS_IRQ_CLR: begin
                    next_s.inten = s.inten & ~pwdata[NUM_EVENTS-1:0]; // RULE_10
                end
                OFS_ENABLE: begin
                    next_s.enable = pwdata[1:0]; // RULE_12
                end
                OFS_KEY_COUNT: begin
                    // out-of-range counts are ignored
                    if (pwdata >= 32'(KEY_COUNT_MIN) && pwdata <= 32'(KEY_COUNT_MAX)) begin
                        next_s.key_count = pwdata[4:0]; // RULE_13
                    end
                end
                OFS_KEY_PTR: begin
                    next_s.key_ptr = pwdata; // RULE_11
                end
                OFS_ADDR_PTR: begin
                    next_s.addr_ptr = pwdata; // RULE_11 RULE_02
                end
                OFS_SCRATCH_PTR: begin
                    next_s.scratch_ptr = pwdata; // RULE_11
                end
                default: begin
                    next_s.enable = s.enable;
                end
            endcase
        end

        // resolution sequencer
        case (s.fsm)
            ST_IDLE: begin
                next_s.mem_req = 1'b0;
                if (start_req && enabled) begin
                    next_s.byte_idx = 5'h00;
                    next_s.key_idx = 4'h0;
                    next_s.fsm = ST_FETCH_ADDR; // RULE_05 RULE_01
                end
            end
            ST_FETCH_ADDR: begin
                // six address bytes from the address pointer onward
                if (!s.mem_req) begin
                    next_s.mem_req = 1'b1;
                    next_s.mem_addr = fetch_base + 32'(s.byte_idx); // RULE_02
                end else if (mem_ack) begin
                    next_s.mem_req = 1'b0;
                    next_s.addr[s.byte_idx[2:0]*8 +: 8] = mem_rdata;
                    if (s.byte_idx == ADDR_LAST) begin
                        next_s.byte_idx = 5'h00;
                        next_s.key_idx = 4'h0; // RULE_15
                        next_s.fsm = ST_FETCH_KEY;
                    end else begin
                        next_s.byte_idx = s.byte_idx + 5'h01;
                    end
                end
            end
            ST_FETCH_KEY: begin
                // sixteen bytes of the current key
                if (!s.mem_req) begin
                    next_s.mem_req = 1'b1;
                    next_s.mem_addr = fetch_base + 32'(s.byte_idx); // RULE_03 RULE_04
                end else if (mem_ack) begin
                    next_s.mem_req = 1'b0;
                    next_s.key[s.byte_idx[3:0]*8 +: 8] = mem_rdata;
                    if (s.byte_idx == KEY_LAST) begin
                        next_s.byte_idx = 5'h00;
                        next_s.chk_start = 1'b1;
                        next_s.fsm = ST_CHECK;
                    end else begin
                        next_s.byte_idx = s.byte_idx + 5'h01;
                    end
                end
            end
            ST_CHECK: begin
                // first match or the last of key_count keys ends the search, else move to the next key
                if (chk.done) begin
                    if (chk.match) begin
                        hw_set[EV_MATCH] = 1'b1; // RULE_08
                        hw_set[EV_DONE] = 1'b1; // RULE_07 RULE_15
                        next_s.last_match = s.key_idx; // RULE_14
                        next_s.fsm = ST_IDLE;
                    end else if ({1'b0, s.key_idx} == s.key_count - 5'h01) begin
                        hw_set[EV_NOMATCH] = 1'b1; // RULE_08
                        hw_set[EV_DONE] = 1'b1; // RULE_07 RULE_15
                        next_s.fsm = ST_IDLE;
                    end else begin
                        next_s.key_idx = s.key_idx + 4'h1; // RULE_15
                        next_s.fsm = ST_FETCH_KEY;
                    end
                end
            end
            default: begin
                next_s.mem_req = 1'b0;
                next_s.fsm = ST_IDLE;
            end
        endcase

        // stop or disable abandons a run; it raises no events unless the key check ends in that same cycle
        if ((stop_req || !enabled) && s.fsm != ST_IDLE) begin
            next_s.mem_req = 1'b0;
            next_s.fsm = ST_IDLE; // RULE_06 RULE_12
        end

        // sticky flags: a hardware set wins over a clear in the same cycle
        next_s.events = (s.events & ~ev_clr) | hw_set; // RULE_16
        next_s.irq = |(next_s.events & next_s.inten);
    end

    // state register with reset values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.fsm <= ST_IDLE;
            s.enable <= ENABLE_RESET;
            s.key_count <= KEY_COUNT_RESET; // RULE_13
            s.key_ptr <= PTR_RESET;
            s.addr_ptr <= PTR_RESET;
            s.scratch_ptr <= PTR_RESET;
        end else begin
            s <= next_s;
        end
    end

    // outputs come straight from the state register
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign mem_req = s.mem_req;
    assign mem_addr = s.mem_addr;
    assign irq = s.irq;
endmodule

// ===== resolver_monitor.sv
// checker for the resolver's apb, memory and interrupt ports
// assumes it is bound to address_resolver and sees only its ports
`timescale 1ns/100ps
module resolver_monitor
    import resolver_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [resolver_pkg::ADDR_W-1:0] paddr,
    input wire logic [resolver_pkg::DATA_W-1:0] pwdata,
    input wire logic [resolver_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic irq
);
    logic en_on;
    logic wr_done;
    logic mapped;
    // decode of completed writes and of the mapped offsets
    assign wr_done = psel && penable && pready && pwrite;
    assign mapped = paddr inside {OFS_START, OFS_STOP, OFS_DONE, OFS_MATCH, OFS_NOMATCH,
        OFS_IRQ_SET, OFS_IRQ_CLR, OFS_STATUS, OFS_ENABLE, OFS_KEY_COUNT, OFS_KEY_PTR,
        OFS_ADDR_PTR, OFS_SCRATCH_PTR};
    // shadow of the enable field as written over the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_on <= 1'b0;
        end else if (wr_done && paddr == OFS_ENABLE) begin
            en_on <= (pwdata[1:0] == ENABLE_ON);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_taken;
        mem_req && mem_ack;
    endsequence
    AST_PREADY_WAIT: assert property (s_wait |=> pready)
        else $error("pready missing after wait state");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_PREADY_CAUSE: assert property (pready |-> psel && penable)
        else $error("pready outside an access");
    AST_MAPPED_OK: assert property (pready && mapped |-> !pslverr)
        else $error("error on mapped offset");
    AST_UNMAPPED_ERR: assert property (pready && !mapped |-> pslverr && (pwrite || prdata == '0))
        else $error("unmapped access not refused");
    AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> !mem_req || $stable(mem_addr))
        else $error("memory address moved while pending");
    AST_MEM_GAP: assert property (s_taken |=> !mem_req)
        else $error("no idle cycle after byte");
    AST_STOP_DROP: assert property (wr_done && paddr == OFS_STOP && pwdata[0] |=> !mem_req [*8])
        else $error("memory reads after stop");
    AST_OFF_QUIET: assert property (!en_on |-> !mem_req)
        else $error("memory read while disabled");
    AST_IRQ_MASKED: assert property (wr_done && paddr == OFS_IRQ_CLR && pwdata[2:0] == 3'h7
        |=> !irq)
        else $error("irq high with all enables cleared");
endmodule
bind address_resolver resolver_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq(irq));

// ===== resolver_ram.sv
// byte-wide ram model answering the resolver's memory read port
// assumes the bench preloads mem through hierarchy while the resolver is idle
`timescale 1ns/100ps
module resolver_ram (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    output logic [7:0] mem_rdata,
    output logic mem_ack
);
    logic [7:0] mem [0:511];
    logic [1:0] wait_cnt;
    int reads;
    // answer at once or after three waits; one-cycle ack; data churns otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 8'h00;
            wait_cnt <= 2'h0;
            reads <= 0;
        end else if (mem_req && !mem_ack && (!slow || wait_cnt == 2'h3)) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[8:0]];
            wait_cnt <= 2'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata; // no stale byte outside an answer
            wait_cnt <= (mem_req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
            if (mem_req && mem_ack) begin
                reads <= reads + 1;
            end
        end
    end
endmodule

// ===== test_address_resolver.sv
// self-checking bench for the private address resolver
// assumes resolver_pkg, the ram model and the monitor are compiled first
`timescale 1ns/100ps
`define chk(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module test_address_resolver;
    import resolver_pkg::*;
    localparam logic [31:0] ADDR_BASE = 32'h00000010;
    localparam logic [31:0] KEY_BASE = 32'h00000020;
    logic pclk, presetn, psel, penable, pwrite, slow, pready, pslverr, mem_req, mem_ack, irq;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, q;
    logic [31:0] mem_addr;
    logic [7:0] mem_rdata;
    logic e;
    logic [11:0] ptrs [3] = '{OFS_KEY_PTR, OFS_ADDR_PTR, OFS_SCRATCH_PTR};
    int err_count, checks, base;
    address_resolver u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .irq(irq));
    resolver_ram u_ram (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
    // 20 MHz clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // one apb transfer: setup, access, hold until pready seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready, prdata and pslverr are read at the rising edge, before it updates them
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h00000000, q, e);
        `chk(nm, x, q)
    endtask
    function automatic logic [7:0] kb(input int n, input int i);
        return 8'(n * 37 + i * 5 + 3);
    endfunction
    // expected hash of a random part under key n
    function automatic logic [23:0] mix(input logic [23:0] p, input int n);
        logic [23:0] acc;
        logic [7:0] k;
        acc = p;
        for (int i = 0; i < KEY_BYTES; i++) begin
            k = kb(n, i);
            acc = {acc[22:0], acc[23]} ^ {k, k ^ p[7:0], k};
        end
        return acc;
    endfunction
    task automatic load_addr(input logic [23:0] p, input logic [23:0] h);
        for (int i = 0; i < 3; i++) begin
            u_ram.mem[ADDR_BASE + i] = h[8*i +: 8];
            u_ram.mem[ADDR_BASE + 3 + i] = p[8*i +: 8];
        end
    endtask
    task automatic wait_irq();
        int t;
        t = 0;
        while (irq !== 1'b1 && t < 3000) begin
            @(negedge pclk);
            t++;
        end
        `chk("irq", 1'b1, irq)
    endtask
    // one resolution with its flags, byte count and cleanup
    task automatic run(input logic [23:0] p, input logic [23:0] h, input int nrd,
                       input logic m, input logic [31:0] st);
        int b;
        load_addr(p, h);
        b = u_ram.reads;
        wr(OFS_START, 32'h00000001);
        wait_irq();
        `chk("byte reads", nrd, u_ram.reads - b)
        rd_chk("done_event", OFS_DONE, 32'h00000001);
        rd_chk("match_event", OFS_MATCH, {31'h0, m});
        rd_chk("nomatch_event", OFS_NOMATCH, {31'h0, !m});
        rd_chk("last_match_index", OFS_STATUS, st);
        wr(OFS_DONE, 32'h00000000);
        wr(OFS_MATCH, 32'h00000000);
        wr(OFS_NOMATCH, 32'h00000000);
        @(negedge pclk);
        `chk("irq after clear", 1'b0, irq)
    endtask
    task automatic tally_and_finish();
        if (err_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        tally_and_finish();
    end
    initial begin
        {psel, penable, pwrite, slow, presetn} = 5'h00;
        paddr = '0;
        pwdata = '0;
        err_count = 0;
        checks = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int n = 0; n < 16; n++) begin
            for (int i = 0; i < KEY_BYTES; i++) u_ram.mem[KEY_BASE + 16 * n + i] = kb(n, i);
        end
        rd_chk("key_count", OFS_KEY_COUNT, 32'h00000001);
        rd_chk("irq_enable_set", OFS_IRQ_SET, 32'h00000000);
        rd_chk("block_enable", OFS_ENABLE, 32'h00000000);
        apb(1'b0, 12'h00C, 32'h00000000, q, e);
        `chk("unmapped error", 1'b1, e)
        foreach (ptrs[j]) begin
            wr(ptrs[j], 32'hA5A50000 + j);
            rd_chk("pointer", ptrs[j], 32'hA5A50000 + j);
        end
        wr(OFS_KEY_PTR, KEY_BASE);
        wr(OFS_ADDR_PTR, ADDR_BASE);
        wr(OFS_KEY_COUNT, 32'h00000000);
        wr(OFS_KEY_COUNT, 32'h00000011);
        rd_chk("key_count", OFS_KEY_COUNT, 32'h00000001);
        wr(OFS_IRQ_SET, 32'h00000007);
        wr(OFS_IRQ_CLR, 32'h00000001);
        rd_chk("irq_enable_set", OFS_IRQ_SET, 32'h00000006);
        rd_chk("irq_enable_clear", OFS_IRQ_CLR, 32'h00000006);
        wr(OFS_IRQ_SET, 32'h00000001);
        rd_chk("irq_enable_clear", OFS_IRQ_CLR, 32'h00000007);
        load_addr(24'h3C5A96, 24'h000000);
        wr(OFS_START, 32'h00000001);
        repeat (50) @(posedge pclk);
        `chk("reads while off", 0, u_ram.reads)
        wr(OFS_ENABLE, 32'h00000003);
        wr(OFS_START, 32'h00000002);
        repeat (50) @(posedge pclk);
        `chk("reads on bit0 clear", 0, u_ram.reads)
        wr(OFS_KEY_COUNT, 32'h00000004);
        run(24'h3C5A96, mix(24'h3C5A96, 2), 6 + 3 * 16, 1'b1, 32'h00000002);
        wr(OFS_KEY_COUNT, 32'h00000010);
        slow <= 1'b1;
        run(24'h81F00D, mix(24'h81F00D, 15), 6 + 256, 1'b1, 32'h0000000F);
        wr(OFS_KEY_COUNT, 32'h00000001);
        slow <= 1'b0;
        run(24'h5577AA, mix(24'h5577AA, 0) ^ 24'h000001, 22, 1'b0, 32'h0000000F);
        wr(OFS_START, 32'h00000001);
        repeat (20) @(posedge pclk);
        wr(OFS_STOP, 32'h00000001);
        // let a byte taken at the stop edge settle into the count first
        @(negedge pclk);
        base = u_ram.reads;
        repeat (300) @(posedge pclk);
        `chk("reads after stop", base, u_ram.reads)
        rd_chk("done_event", OFS_DONE, 32'h00000000);
        wr(OFS_IRQ_CLR, 32'h00000007);
        rd_chk("irq_enable_set", OFS_IRQ_SET, 32'h00000000);
        tally_and_finish();
    end
endmodule
